/* shared/hrap_pkg.sv */
// constants and types for the host register access port
package hrap_pkg;
  localparam logic [6:0] ADDR_BASE  = 7'h48;   // base address, strap code 0
  localparam int         SEL_HI     = 6;
  localparam int         SEL_LO     = 3;
  localparam int         CH_HI      = 2;
  localparam int         CH_LO      = 1;
  localparam int         DIR_BIT    = 7;       // read/write on four-wire link
  localparam int         ADDR_RW    = 0;       // read/write in slave address
  localparam logic [3:0] SEL_FIFO   = 4'h0;
  localparam logic [3:0] ACK_SLOT   = 4'h8;
  localparam logic [2:0] BIT_LAST   = 3'h7;
  localparam int         DATA_W     = 8;
  localparam int         FIFO_D     = 8;

  typedef enum logic [2:0] {
    TW_IDLE  = 3'b000,
    TW_ADDR  = 3'b001,
    TW_SUB   = 3'b010,
    TW_WDATA = 3'b011,
    TW_RDATA = 3'b100,
    TW_WAIT  = 3'b101
  } hrap_tw_e;

  // one register access towards the uart core
  typedef struct packed {
    logic [3:0] sel;
    logic [7:0] data;
    logic       wr;
    logic       rd;
  } hrap_req_s;
endpackage : hrap_pkg

/* src/hrap_top.sv */
// two-wire and four-wire register access port with transmit fifo
`timescale 1ns/1ps

module hrap_fifo #(
  parameter int W = 8,
  parameter int D = 8
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  // fill side
  input  wire logic [W-1:0] inData,
  input  wire logic         inValid,
  output      logic         inReady,
  // drain side
  output      logic [W-1:0] outData,
  output      logic         outValid,
  input  wire logic         outReady
);
  localparam int AW = $clog2(D);
  logic [W-1:0]  mem [D];
  logic [AW-1:0] wrPtr_ff, nxt_wrPtr, rdPtr_ff, nxt_rdPtr;
  logic [AW:0]   cnt_ff, nxt_cnt;
  logic          push, pop;

  always_comb begin
    push      = inValid && inReady;
    pop       = outValid && outReady;
    nxt_wrPtr = push ? AW'(wrPtr_ff + 1'b1) : wrPtr_ff;
    nxt_rdPtr = pop ? AW'(rdPtr_ff + 1'b1) : rdPtr_ff;
    nxt_cnt   = (AW+1)'(cnt_ff + push - pop);
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wrPtr_ff <= '0;
      rdPtr_ff <= '0;
      cnt_ff   <= '0;
    end else begin
      wrPtr_ff <= nxt_wrPtr;
      rdPtr_ff <= nxt_rdPtr;
      cnt_ff   <= nxt_cnt;
    end
  end

  always_ff @(posedge clk) begin
    if (push) mem[wrPtr_ff] <= inData;
  end

  assign inReady  = cnt_ff != (AW+1)'(D);
  assign outValid = cnt_ff != '0;
  assign outData  = mem[rdPtr_ff];
endmodule : hrap_fifo

module hrap_top import hrap_pkg::*; (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              rst_n,
  // two-wire link
  input  wire logic              scl,
  input  wire logic              sdaIn,
  output      logic              sdaOut,
  output      logic              sdaOeN,
  input  wire logic [1:0]        addr_strap_hi,
  input  wire logic [1:0]        addr_strap_lo,
  // four-wire link
  input  wire logic              sclk,
  input  wire logic              csN,
  input  wire logic              mosi,
  output      logic              miso,
  output      logic              misoOeN,
  // register port towards the uart core
  output      hrap_req_s         regReq,
  input  wire logic [DATA_W-1:0] regRdData,
  output      logic              txOverflow,
  // transmit fifo drain
  output      logic [DATA_W-1:0] txData,
  output      logic              txValid,
  input  wire logic              txReady
);
  logic [8:0]  s1_ff, s2_ff, s3_ff;
  logic        sclS, sdaS, sclkS, csNS, mosiS, sclP, sdaP, sclkP, csNP;
  logic        start, stop, sclRise, sclFall, ckRise, ckFall;
  logic [6:0]  myAddr;
  hrap_tw_e    tw_ff, nxt_tw;
  logic [3:0]  twCnt_ff, nxt_twCnt;
  logic [7:0]  twSh_ff, nxt_twSh, rdBuf_ff, nxt_rdBuf;
  logic [7:0]  spSh_ff, nxt_spSh;
  logic [2:0]  spCnt_ff, nxt_spCnt;
  logic        spFirst_ff, nxt_spFirst, spRd_ff, nxt_spRd;
  logic [3:0]  sel_ff, nxt_sel;
  hrap_req_s   req_ff, nxt_req;
  logic        sdaOeN_ff, nxt_sdaOeN, miso_ff, nxt_miso;
  logic        misoOeN_ff, nxt_misoOeN, ovf_ff, nxt_ovf;
  logic        push_ff, nxt_push, fifoReady;
  logic [7:0]  pushData_ff, nxt_pushData, twByte, spByte;
  logic        canPush;

  always_comb begin
    {sclS, sdaS, sclkS, csNS, mosiS} = s2_ff[8:4];
    {sclP, sdaP, sclkP, csNP}        = s3_ff[8:5];
    start   = sclS && sclP && sdaP && !sdaS;
    stop    = sclS && sclP && !sdaP && sdaS;
    sclRise = sclS && !sclP;
    sclFall = !sclS && sclP;
    ckRise  = sclkS && !sclkP && !csNS;
    ckFall  = !sclkS && sclkP && !csNS;
    myAddr  = ADDR_BASE + {3'h0, s2_ff[3:0]};
    twByte  = {twSh_ff[6:0], sdaS};
    spByte  = {spSh_ff[6:0], mosiS};
    canPush = fifoReady && !push_ff;
  end

  always_comb begin
    nxt_tw = tw_ff;  nxt_twCnt = twCnt_ff;  nxt_twSh = twSh_ff;
    nxt_spSh = spSh_ff;  nxt_spCnt = spCnt_ff;  nxt_spFirst = spFirst_ff;
    nxt_spRd = spRd_ff;  nxt_sel = sel_ff;  nxt_sdaOeN = sdaOeN_ff;
    nxt_miso = miso_ff;  nxt_misoOeN = csNS;  nxt_ovf = ovf_ff;
    nxt_push = 1'b0;  nxt_pushData = pushData_ff;
    nxt_rdBuf = req_ff.rd ? regRdData : rdBuf_ff;
    nxt_req = req_ff;  nxt_req.wr = 1'b0;  nxt_req.rd = 1'b0;
    // two-wire slave
    if (start) begin
      nxt_tw = TW_ADDR;  nxt_twCnt = '0;  nxt_sdaOeN = 1'b1;
    end else if (stop) begin
      nxt_tw = TW_IDLE;  nxt_sdaOeN = 1'b1;
    end else if (sclRise && tw_ff != TW_IDLE) begin
      if (twCnt_ff != ACK_SLOT) begin
        nxt_twSh  = twByte;
        nxt_twCnt = twCnt_ff + 4'h1;
      end else begin
        nxt_twCnt = '0;
        if (tw_ff == TW_RDATA) begin
          if (sdaS) nxt_tw = TW_WAIT;
          else if (sdaOeN_ff) begin
            // our own address ack is not a host ack
            nxt_req.rd = 1'b1;
          end
        end
      end
    end else if (sclFall && tw_ff != TW_IDLE && tw_ff != TW_WAIT) begin
      if (twCnt_ff == ACK_SLOT) begin
        nxt_sdaOeN = 1'b1;
        case (tw_ff)
          TW_ADDR: if (twSh_ff[7:1] == myAddr) begin
            nxt_sdaOeN = 1'b0;
            nxt_tw = twSh_ff[ADDR_RW] ? TW_RDATA : TW_SUB;
            nxt_req.rd = twSh_ff[ADDR_RW];
            nxt_req.sel = sel_ff;
          end else nxt_tw = TW_WAIT;
          TW_SUB: begin
            nxt_sdaOeN = 1'b0;
            nxt_sel = twSh_ff[SEL_HI:SEL_LO];
            nxt_tw = TW_WDATA;
          end
          TW_WDATA: if (sel_ff == SEL_FIFO) begin
            if (canPush) begin
              nxt_sdaOeN = 1'b0;
              nxt_push = 1'b1;
              nxt_pushData = twSh_ff;
            end
          end else begin
            nxt_sdaOeN = 1'b0;
            nxt_req = '{sel: sel_ff, data: twSh_ff, wr: 1'b1, rd: 1'b0};
          end
          default: ;
        endcase
      end else if (tw_ff == TW_RDATA) begin
        if (twCnt_ff == '0) begin
          nxt_twSh = rdBuf_ff;
          nxt_sdaOeN = rdBuf_ff[DATA_W-1];
        // each rise shifts the byte up, so the next bit sits at the top
        end else nxt_sdaOeN = twSh_ff[DATA_W-1];
      end else if (twCnt_ff == '0) nxt_sdaOeN = 1'b1;
    end
    // four-wire slave, mode 0
    if (csNS) begin
      nxt_spCnt = '0;  nxt_spFirst = 1'b1;  nxt_spRd = 1'b0;
    end else if (ckRise) begin
      nxt_spSh = spByte;
      nxt_spCnt = spCnt_ff + 3'h1;
      if (spCnt_ff == BIT_LAST) begin
        if (spFirst_ff) begin
          nxt_spFirst = 1'b0;
          nxt_spRd = spByte[DIR_BIT];
          nxt_sel = spByte[SEL_HI:SEL_LO];
          nxt_req.sel = spByte[SEL_HI:SEL_LO];
          nxt_req.rd = spByte[DIR_BIT];
        end else if (spRd_ff) nxt_req.rd = 1'b1;
        else if (sel_ff == SEL_FIFO) begin
          if (canPush) begin
            nxt_push = 1'b1;
            nxt_pushData = spByte;
          end else nxt_ovf = 1'b1;
        end else nxt_req = '{sel: sel_ff, data: spByte, wr: 1'b1, rd: 1'b0};
      end
    end else if (ckFall && spRd_ff) begin
      if (spCnt_ff == '0) begin
        nxt_spSh = rdBuf_ff;
        nxt_miso = rdBuf_ff[DATA_W-1];
      end else nxt_miso = spSh_ff[DATA_W-1];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      // idle pin levels, so no false edge follows reset
      s1_ff <= 9'h1A0;  s2_ff <= 9'h1A0;  s3_ff <= 9'h1A0;
      tw_ff <= TW_IDLE;  twCnt_ff <= '0;  twSh_ff <= '0;  rdBuf_ff <= '0;
      spSh_ff <= '0;  spCnt_ff <= '0;  spFirst_ff <= 1'b1;  spRd_ff <= 1'b0;
      sel_ff <= '0;  req_ff <= '0;  sdaOeN_ff <= 1'b1;  miso_ff <= 1'b0;
      misoOeN_ff <= 1'b1;  ovf_ff <= 1'b0;  push_ff <= 1'b0;
      pushData_ff <= '0;
    end else begin
      s1_ff <= {scl, sdaIn, sclk, csN, mosi, addr_strap_hi, addr_strap_lo};
      s2_ff <= s1_ff;  s3_ff <= s2_ff;
      tw_ff <= nxt_tw;  twCnt_ff <= nxt_twCnt;  twSh_ff <= nxt_twSh;
      rdBuf_ff <= nxt_rdBuf;  spSh_ff <= nxt_spSh;  spCnt_ff <= nxt_spCnt;
      spFirst_ff <= nxt_spFirst;  spRd_ff <= nxt_spRd;  sel_ff <= nxt_sel;
      req_ff <= nxt_req;  sdaOeN_ff <= nxt_sdaOeN;  miso_ff <= nxt_miso;
      misoOeN_ff <= nxt_misoOeN;  ovf_ff <= nxt_ovf;  push_ff <= nxt_push;
      pushData_ff <= nxt_pushData;
    end
  end

  // fifo ready gates the ack, so a stalled drain turns into a nack
  hrap_fifo #(.W(DATA_W), .D(FIFO_D)) u_txFifo (
    .clk     (clk),
    .rst_n   (rst_n),
    .inData  (pushData_ff),
    .inValid (push_ff),
    .inReady (fifoReady),
    .outData (txData),
    .outValid(txValid),
    .outReady(txReady)
  );

  assign sdaOut     = 1'b0;
  assign sdaOeN     = sdaOeN_ff;
  assign miso       = miso_ff;
  assign misoOeN    = misoOeN_ff;
  assign regReq     = req_ff;
  assign txOverflow = ovf_ff;

  default clocking dc @(posedge clk); endclocking
  default disable iff (!rst_n);

  chk_addr_ack: assert property (sclFall && tw_ff == TW_ADDR &&
    twCnt_ff == ACK_SLOT && twSh_ff[7:1] == myAddr |=> !sdaOeN_ff)
    else $error("matching address not acked");
  chk_addr_skip: assert property (sclFall && tw_ff == TW_ADDR &&
    twCnt_ff == ACK_SLOT && twSh_ff[7:1] != myAddr |=> tw_ff == TW_WAIT)
    else $error("foreign address not ignored");
  chk_sub_sel: assert property (sclFall && tw_ff == TW_SUB &&
    twCnt_ff == ACK_SLOT |=> sel_ff == $past(twSh_ff[SEL_HI:SEL_LO]))
    else $error("register select not from bits 6 to 3");
  chk_full_nack: assert property (sclFall && tw_ff == TW_WDATA &&
    twCnt_ff == ACK_SLOT && sel_ff == SEL_FIFO && !canPush |=> sdaOeN_ff)
    else $error("full fifo byte acked");
  chk_ack_release: assert property (sclFall && twCnt_ff == '0 &&
    tw_ff inside {TW_SUB, TW_WDATA} |=> sdaOeN_ff)
    else $error("sda not released after ack");
  sequence spAddrDone;
    ckRise && spFirst_ff && spCnt_ff == BIT_LAST;
  endsequence
  chk_spi_dir: assert property (spAddrDone |=>
    spRd_ff == $past(spSh_ff[DIR_BIT-1]))
    else $error("direction not from bit 7");
  chk_spi_push: assert property (ckRise && !spFirst_ff && !spRd_ff &&
    spCnt_ff == BIT_LAST && sel_ff == SEL_FIFO && canPush
    |=> push_ff ##1 !push_ff)
    else $error("fifo byte not pushed once");
  chk_no_incr: assert property (req_ff.wr || req_ff.rd |->
    req_ff.sel == sel_ff || $past(csNS) || tw_ff == TW_RDATA)
    else $error("register select moved during burst");
  chk_cs_frame: assert property (csNS |=> misoOeN_ff && spFirst_ff)
    else $error("four-wire not idle without chip select");
  chk_rd_release: assert property (sclFall && tw_ff == TW_RDATA &&
    twCnt_ff == ACK_SLOT |=> sdaOeN_ff)
    else $error("sda not released for host ack");
  chk_own_ack: assert property (sclRise && tw_ff == TW_RDATA &&
    twCnt_ff == ACK_SLOT && !sdaOeN_ff |=> !req_ff.rd)
    else $error("own address ack taken as host ack");
endmodule : hrap_top

/* testbench/hrap_host_model.sv */
// host model that masters the two-wire and four-wire links
`timescale 1ns/1ps
module hrap_host_model (
  // clock
  input  wire logic clk,
  // two-wire link, a released sda reads as pulled up
  output      logic scl = 1'b1,
  output      logic sdaHost = 1'b1,
  input  wire logic sda,
  // four-wire link, sclk rests low outside frames
  output      logic sclk = 1'b0,
  output      logic csN = 1'b1,
  output      logic mosi = 1'b0,
  input  wire logic miso
);
  task automatic w(input int n);
    repeat (n) @(posedge clk);
  endtask : w

  task automatic step(input logic c, input logic d);
    w(12);
    scl     <= c;
    sdaHost <= d;
  endtask : step

  // also serves as repeated start
  task automatic tw_start();
    step(1'b0, 1'b1);
    step(1'b1, 1'b1);
    step(1'b1, 1'b0);
    step(1'b0, 1'b0);
  endtask : tw_start

  task automatic tw_stop();
    step(1'b0, 1'b0);
    step(1'b1, 1'b0);
    step(1'b1, 1'b1);
  endtask : tw_stop

  // nack high leaves sda released in the ack slot
  task automatic tw_xfer(input logic [7:0] tx, input logic nack,
                         output logic [7:0] rx, output logic ack);
    logic [8:0] s;
    logic [8:0] q;
    s = {tx, nack};
    for (int i = 8; i >= 0; i--) begin
      step(1'b0, s[i]);
      step(1'b1, s[i]);
      w(6);
      q[i] = sda;
      step(1'b0, s[i]);
    end
    rx  = q[8:1];
    ack = !q[0];
  endtask : tw_xfer

  task automatic fw_cs(input logic v);
    w(16);
    csN <= v;
    w(16);
  endtask : fw_cs

  task automatic fw_xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      w(8);
      mosi <= tx[i];
      w(8);
      sclk  <= 1'b1;
      rx[i] = miso;
      w(16);
      sclk <= 1'b0;
    end
  endtask : fw_xfer
endmodule : hrap_host_model

/* testbench/host_register_access_port_bench.sv */
// self-checking bench for the host register access port
`timescale 1ns/1ps
module host_register_access_port_bench;
  import hrap_pkg::*;
  logic       clk = 1'b0;
  logic       rst_n = 1'b0;
  logic [1:0] strapHi = 2'h0;
  logic [1:0] strapLo = 2'h0;
  logic [7:0] rdVal = 8'h00;
  logic       txReady = 1'b0;
  logic       scl, sdaHost, sclk, csN, mosi, miso, misoOeN;
  logic       sdaOut, sdaOeN, txOverflow, txValid, ack;
  logic [7:0] txData, rx;
  logic [6:0] dev;
  hrap_req_s  regReq;
  wire        sda = sdaHost & (sdaOeN | sdaOut);
  int         n_errors = 0;
  int         checks = 0;
  int         wrQ[$];
  int         rdQ[$];
  int         txQ[$];

  hrap_top hrap_top_i (.clk(clk), .rst_n(rst_n), .scl(scl), .sdaIn(sda),
    .sdaOut(sdaOut), .sdaOeN(sdaOeN), .addr_strap_hi(strapHi),
    .addr_strap_lo(strapLo), .sclk(sclk), .csN(csN), .mosi(mosi),
    .miso(miso), .misoOeN(misoOeN), .regReq(regReq), .regRdData(rdVal),
    .txOverflow(txOverflow), .txData(txData), .txValid(txValid),
    .txReady(txReady));
  hrap_host_model hrap_host_model_i (.clk(clk), .scl(scl),
    .sdaHost(sdaHost), .sda(sda), .sclk(sclk), .csN(csN), .mosi(mosi),
    .miso(miso));

  initial forever #2.5 clk = ~clk;

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic finish_test();
    $display("errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : finish_test

  // an empty queue yields a value no port can show
  function automatic int pop(ref int q[$]);
    return q.size() ? q.pop_front() : -1;
  endfunction : pop

  // model of one written byte, returns the owed ack
  function automatic logic model_wr(input logic [3:0] sel,
                                    input logic [7:0] b);
    if (sel != SEL_FIFO)
      wrQ.push_back({sel, b});
    else if (txQ.size() < FIFO_D)
      txQ.push_back(b);
    else
      return 1'b0;
    return 1'b1;
  endfunction : model_wr

  always @(posedge clk) begin
    if (regReq.wr === 1'b1)
      check({regReq.sel, regReq.data}, pop(wrQ));
    if (regReq.rd === 1'b1)
      check(regReq.sel, pop(rdQ));
    if (txValid === 1'b1 && txReady === 1'b1)
      check(txData, pop(txQ));
  end

  task automatic tw_ops(input logic [3:0] sel, input logic rd, input int n);
    logic [7:0] b;
    logic [8:0] e;
    hrap_host_model_i.tw_start();
    hrap_host_model_i.tw_xfer({dev, 1'b0}, 1'b1, rx, ack);
    check(ack, 1'b1);
    b = {1'($urandom), sel, 2'b00, 1'($urandom)};
    hrap_host_model_i.tw_xfer(b, 1'b1, rx, ack);
    check(ack, 1'b1);
    if (rd) begin
      hrap_host_model_i.tw_start();
      rdQ.push_back(sel);
      hrap_host_model_i.tw_xfer({dev, 1'b1}, 1'b1, rx, ack);
      check(ack, 1'b1);
    end
    for (int i = 0; i < n; i++) begin
      b = rd ? 8'hFF : 8'($urandom);
      if (rd && i < n - 1)
        rdQ.push_back(sel);
      e = rd ? {rdVal, i < n - 1} : {b, model_wr(sel, b)};
      hrap_host_model_i.tw_xfer(b, !rd || i == n - 1, rx, ack);
      check({rx, ack}, e);
    end
    hrap_host_model_i.tw_stop();
  endtask : tw_ops

  task automatic fw_ops(input logic [3:0] sel, input logic rd, input int n);
    logic [7:0] b;
    hrap_host_model_i.fw_cs(1'b0);
    check(misoOeN, 1'b0);
    if (rd)
      rdQ.push_back(sel);
    b = {rd, sel, 2'b00, 1'($urandom)};
    hrap_host_model_i.fw_xfer(b, rx);
    for (int i = 0; i < n; i++) begin
      b = 8'($urandom);
      if (rd)
        rdQ.push_back(sel);
      else
        void'(model_wr(sel, b));
      hrap_host_model_i.fw_xfer(b, rx);
      if (rd)
        check(rx, rdVal);
    end
    hrap_host_model_i.fw_cs(1'b1);
    check(misoOeN, 1'b1);
  endtask : fw_ops

  initial begin
    void'($urandom(32'hFD501852));
    repeat (5) @(posedge clk);
    check({sdaOeN, misoOeN, txValid, txOverflow}, 4'hC);
    check(regReq, 14'h0);
    strapHi <= 2'($urandom);
    strapLo <= 2'($urandom);
    rdVal   <= 8'($urandom);
    rst_n   <= 1'b1;
    repeat (4) @(posedge clk);
    dev = ADDR_BASE + {3'h0, strapHi, strapLo};
    tw_ops(4'($urandom_range(15, 1)), 1'b0, 3);
    tw_ops(4'($urandom_range(15, 1)), 1'b1, 3);
    hrap_host_model_i.tw_start();
    hrap_host_model_i.tw_xfer({dev ^ 7'h10, 1'b0}, 1'b1, rx, ack);
    check(ack, 1'b0);
    hrap_host_model_i.tw_stop();
    fw_ops(4'($urandom_range(15, 1)), 1'b0, 2);
    fw_ops(4'($urandom_range(15, 1)), 1'b1, 2);
    fw_ops(SEL_FIFO, 1'b1, 2);
    fw_ops(SEL_FIFO, 1'b0, FIFO_D + 1);
    check(txOverflow, 1'b1);
    tw_ops(SEL_FIFO, 1'b0, 1);
    txReady <= 1'b1;
    repeat (FIFO_D * 4) @(posedge clk);
    check({txValid, 8'(wrQ.size() + rdQ.size() + txQ.size())}, 9'h0);
    finish_test();
  end

  initial begin
    repeat (90000) @(posedge clk);
    n_errors++;
    finish_test();
  end
endmodule : host_register_access_port_bench
